// ### hw/psv_config_regs.sv
// Supervisor configuration register bank with the logic its fields steer
`timescale 1ns/10ps
module psv_config_regs
    import psv_pkg::*;
#(
    parameter int unsigned SS_T1_CYC  = SS_T1_MS * US_PER_MS * CLK_MHZ,
    parameter int unsigned SS_T2_CYC  = SS_T2_MS * US_PER_MS * CLK_MHZ,
    parameter int unsigned SS_T3_CYC  = SS_T3_MS * US_PER_MS * CLK_MHZ,
    parameter int unsigned RT_SLOW_CYC = RT_SLOW_UNIT_S * US_PER_S * CLK_MHZ
)
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // SMBus register port
    input  wire logic       i_smb_wr,
    input  wire logic       i_smb_rd,
    input  wire logic [7:0] i_smb_cmd,
    input  wire logic [7:0] i_smb_wdata,
    output logic [7:0]      o_smb_rdata,
    output logic            o_smb_ack,
    output logic            o_smb_nack,
    // Shadow EEPROM load port
    input  wire logic       i_test_download,
    output logic            o_ee_rd_req,
    output logic [15:0]     o_ee_rd_addr,
    input  wire logic       i_ee_rd_valid,
    input  wire logic [7:0] i_ee_rd_data,
    output logic            o_cfg_loaded,
    // Pins from outside
    input  wire psv_pins_t  i_pins,
    input  wire logic       i_dc_good_internal,
    // Host support inputs
    input  wire logic       i_host_mains_gate,
    input  wire logic       i_host_ac_sense,
    input  wire logic       i_host_on_request,
    // Monitor-four shared pin and indications
    output logic            o_mon4_pin_o,
    output logic            o_mon4_pin_oe,
    output logic            o_mon4_flag,
    output logic            o_mon4_ov,
    output logic            o_mon4_uv,
    // Supply control outputs
    output logic            o_power_enable_output,
    output logic            o_fault_indicator_output,
    output logic            o_oc_status,
    output logic            o_mains_status_output,
    output logic            o_ac_good_output,
    output logic            o_share_clamp_88,
    output logic [7:0]      o_ref_level,
    output logic            o_softstart_done
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;
    psv_pins_t        pin;

    for (genvar g = 0; g < PIN_W; g++) begin : g_sync
        always_ff @(posedge i_sys_clk) begin
            if (!i_reset_n) begin
                meta_q[g] <= 1'b0;
                sync_q[g] <= 1'b0;
            end else begin
                meta_q[g] <= i_pins[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end
    assign pin = psv_pins_t'(sync_q);

    // ------------------------------------------------------------------
    // Registers and power-up load
    // ------------------------------------------------------------------
    psv_mon4_t     mon4_q;
    psv_ss_t       ss_q;
    psv_flt_t      flt_q;
    psv_rst_t      rst_q;
    psv_ld_state_t ld_q;
    logic [7:0]    ld_cmd;
    logic          running;
    logic          mapped;
    logic          wr_ok;

    always_comb begin
        case (ld_q)
            LD_MON4:  ld_cmd = REG_MON4;
            LD_SS:    ld_cmd = REG_SS_LOCK;
            LD_FAULT: ld_cmd = REG_FAULT;
            default:  ld_cmd = REG_RESTART;
        endcase
    end

    assign running      = (ld_q == LD_RUN);
    assign o_cfg_loaded = running;
    assign o_ee_rd_req  = !running;
    assign o_ee_rd_addr = EE_BASE | {8'h00, ld_cmd};

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ld_q <= LD_MON4;
        end else begin
            case (ld_q)
                LD_MON4:  if (i_ee_rd_valid) ld_q <= LD_SS;
                LD_SS:    if (i_ee_rd_valid) ld_q <= LD_FAULT;
                LD_FAULT: if (i_ee_rd_valid) ld_q <= LD_RST;
                LD_RST:   if (i_ee_rd_valid) ld_q <= LD_RUN;
                default:  if (i_test_download) ld_q <= LD_MON4;
            endcase
        end
    end

    assign mapped = (i_smb_cmd == REG_MON4) || (i_smb_cmd == REG_SS_LOCK)
                 || (i_smb_cmd == REG_FAULT) || (i_smb_cmd == REG_RESTART);
    assign wr_ok  = running && i_smb_wr && mapped && !ss_q.lock;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            mon4_q <= psv_mon4_t'(CFG_RESET_VAL);
            ss_q   <= psv_ss_t'(CFG_RESET_VAL);
            flt_q  <= psv_flt_t'(CFG_RESET_VAL);
            rst_q  <= psv_rst_t'(CFG_RESET_VAL);
        end else if (!running && i_ee_rd_valid) begin
            case (ld_q)
                LD_MON4:  mon4_q <= psv_mon4_t'(i_ee_rd_data);
                LD_SS:    ss_q   <= psv_ss_t'(i_ee_rd_data);
                LD_FAULT: flt_q  <= psv_flt_t'(i_ee_rd_data);
                default:  rst_q  <= psv_rst_t'(i_ee_rd_data);
            endcase
        end else if (wr_ok) begin
            if (i_smb_cmd == REG_MON4) begin
                mon4_q <= psv_mon4_t'(i_smb_wdata);
            end else if (i_smb_cmd == REG_SS_LOCK) begin
                ss_q <= psv_ss_t'(i_smb_wdata);
            end else if (i_smb_cmd == REG_FAULT) begin
                flt_q <= psv_flt_t'(i_smb_wdata);
            end else begin
                rst_q <= psv_rst_t'(i_smb_wdata);
            end
        end
    end

    // ------------------------------------------------------------------
    // SMBus answers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_smb_rdata <= RD_UNMAPPED;
            o_smb_ack   <= 1'b0;
            o_smb_nack  <= 1'b0;
        end else begin
            o_smb_ack  <= wr_ok || (running && i_smb_rd && mapped);
            o_smb_nack <= (i_smb_wr || i_smb_rd) && !(wr_ok || (running && i_smb_rd && mapped));
            if (i_smb_rd) begin
                if (i_smb_cmd == REG_MON4) begin
                    o_smb_rdata <= mon4_q;
                end else if (i_smb_cmd == REG_SS_LOCK) begin
                    o_smb_rdata <= ss_q;
                end else if (i_smb_cmd == REG_FAULT) begin
                    o_smb_rdata <= flt_q;
                end else if (i_smb_cmd == REG_RESTART) begin
                    o_smb_rdata <= rst_q;
                end else begin
                    o_smb_rdata <= RD_UNMAPPED;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Monitor four
    // ------------------------------------------------------------------
    logic m4_hi_q;
    logic m4_set;
    logic m4_clr;
    logic m4_hi_band;

    // Codes 011/100 use the 1.25/1.35 V pair, the others 1.15/1.25 V
    assign m4_hi_band = (mon4_q.mode == M4_POS_UV) || (mon4_q.mode == M4_NEG_OV);
    assign m4_set     = m4_hi_band ? pin.m4_above_1v35 : pin.m4_above_1v25;
    assign m4_clr     = m4_hi_band ? !pin.m4_above_1v25 : !pin.m4_above_1v15;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            m4_hi_q <= 1'b0;
        end else if (m4_set) begin
            m4_hi_q <= 1'b1;
        end else if (m4_clr) begin
            m4_hi_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_mon4_flag <= 1'b0;
            o_mon4_ov   <= 1'b0;
            o_mon4_uv   <= 1'b0;
        end else begin
            o_mon4_flag <= 1'b0;
            o_mon4_ov   <= 1'b0;
            o_mon4_uv   <= 1'b0;
            case (mon4_q.mode)
                M4_POS_OV: begin
                    o_mon4_flag <= m4_hi_q;
                    o_mon4_ov   <= m4_hi_q;
                end
                M4_POS_UV: begin
                    o_mon4_flag <= m4_hi_q;
                    o_mon4_uv   <= !m4_hi_q;
                end
                M4_NEG_OV: begin
                    o_mon4_flag <= m4_hi_q;
                    o_mon4_ov   <= !m4_hi_q;
                end
                M4_NEG_UV: begin
                    o_mon4_flag <= m4_hi_q;
                    o_mon4_uv   <= m4_hi_q;
                end
                M4_FLAG:   o_mon4_flag <= m4_hi_q;
                default:   o_mon4_flag <= 1'b0;
            endcase
        end
    end

    assign o_mon4_pin_oe = (mon4_q.mode == M4_DCOK_A) || (mon4_q.mode == M4_DCOK_B);

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_mon4_pin_o <= 1'b0;
        end else begin
            o_mon4_pin_o <= o_mon4_pin_oe && i_dc_good_internal;
        end
    end

    // ------------------------------------------------------------------
    // Overcurrent ride-through
    // ------------------------------------------------------------------
    logic [TMR_W-1:0] rt_period;
    logic [TMR_W-1:0] rt_mult;
    logic             rt_hit;
    logic             oc_fault_q;

    assign rt_mult   = TMR_W'(rst_q.rt_sel) + TMR_W'(1);
    assign rt_period = flt_q.fast_rt ? TMR_W'(RT_FAST_CYC) * rt_mult
                                     : TMR_W'(RT_SLOW_CYC) * rt_mult;

    psv_timer u_rt_timer (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_run     (pin.overcurrent && !oc_fault_q),
        .i_period  (rt_period),
        .o_hit     (rt_hit)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            oc_fault_q <= 1'b0;
        end else if (!pin.overcurrent) begin
            oc_fault_q <= 1'b0;
        end else if (rt_hit) begin
            oc_fault_q <= 1'b1;
        end
    end

    assign o_oc_status = pin.overcurrent;

    // ------------------------------------------------------------------
    // Fault sources, fault indicator and supply restart
    // ------------------------------------------------------------------
    logic oc_eff;
    logic gnd_fault;
    logic fault_now;
    logic fault_latch_q;
    logic off_latch_q;
    logic on_req;
    logic on_req_q;
    logic mains_ok;
    logic supply_on;
    logic supply_on_q;

    assign oc_eff    = oc_fault_q && !flt_q.oc_mask;
    assign gnd_fault = !pin.ground_ok && !flt_q.gnd_dis;
    assign fault_now = oc_eff || gnd_fault || pin.ov_fault || pin.uv_fault;
    assign on_req    = rst_q.micro_pson ? i_host_on_request : pin.on_request;
    assign mains_ok  = pin.mains_present;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            fault_latch_q <= 1'b0;
        end else if (fault_now) begin
            fault_latch_q <= 1'b1;
        end else if (!flt_q.latch || (on_req_q && !on_req)) begin
            fault_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            on_req_q <= 1'b0;
        end else begin
            on_req_q <= on_req;
        end
    end

    // Latch off on uv/oc; set wins
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            off_latch_q <= 1'b0;
        end else if (!rst_q.restart && (oc_eff || pin.uv_fault)) begin
            off_latch_q <= 1'b1;
        end else if (!on_req || !mains_ok) begin
            off_latch_q <= 1'b0;
        end
    end

    assign supply_on = on_req && mains_ok && !fault_now && !off_latch_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            supply_on_q              <= 1'b0;
            o_power_enable_output    <= 1'b0;
            o_fault_indicator_output <= 1'b0;
        end else begin
            supply_on_q              <= supply_on;
            o_power_enable_output    <= supply_on ~^ flt_q.pen_pol;
            o_fault_indicator_output <= (flt_q.latch ? fault_latch_q : fault_now)
                                        ~^ flt_q.fault_pol;
        end
    end

    // ------------------------------------------------------------------
    // Mains status, ac-good and share clamp
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_mains_status_output <= 1'b0;
            o_ac_good_output      <= 1'b0;
            o_share_clamp_88      <= 1'b0;
        end else begin
            o_mains_status_output <= mains_ok && (!rst_q.micro_ac_good_output || i_host_mains_gate);
            if (rst_q.micro_ac_sense) begin
                o_ac_good_output <= i_host_ac_sense;
            end else begin
                o_ac_good_output <= rst_q.ac_mode ? pin.ac_sense_alt : pin.ac_sense_one;
            end
            o_share_clamp_88 <= rst_q.clamp88;
        end
    end

    // ------------------------------------------------------------------
    // Soft-start ramp
    // ------------------------------------------------------------------
    logic [TMR_W-1:0] ss_step;
    logic             ss_hit;

    always_comb begin
        case (ss_q.rise)
            2'b00:   ss_step = TMR_W'(SS_T0_CYC / RAMP_STEPS);
            2'b01:   ss_step = TMR_W'(SS_T1_CYC / RAMP_STEPS);
            2'b10:   ss_step = TMR_W'(SS_T2_CYC / RAMP_STEPS);
            default: ss_step = TMR_W'(SS_T3_CYC / RAMP_STEPS);
        endcase
    end

    psv_timer u_ss_timer (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_run     (supply_on_q && !o_softstart_done),
        .i_period  (ss_step),
        .o_hit     (ss_hit)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_ref_level      <= 8'h00;
            o_softstart_done <= 1'b0;
        end else if (!supply_on_q) begin
            o_ref_level      <= 8'h00;
            o_softstart_done <= 1'b0;
        end else if (ss_hit) begin
            o_ref_level      <= o_ref_level + 8'h01;
            o_softstart_done <= (o_ref_level == 8'hFE);
        end
    end
endmodule : psv_config_regs

// ### hw/psv_pkg.sv
// Package: constants and field layouts of the supervisor bank
package psv_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ        = 10;
    localparam int unsigned SS_T0_US       = 300;
    localparam int unsigned SS_T1_MS       = 10;
    localparam int unsigned SS_T2_MS       = 20;
    localparam int unsigned SS_T3_MS       = 40;
    localparam int unsigned RT_SLOW_UNIT_S = 1;
    localparam int unsigned RT_FAST_UNIT_US = 128;
    localparam int unsigned US_PER_MS      = 1000;
    localparam int unsigned US_PER_S       = 1000000;
    localparam int unsigned SS_T0_CYC      = SS_T0_US * CLK_MHZ;
    localparam int unsigned RT_FAST_CYC    = RT_FAST_UNIT_US * CLK_MHZ;
    localparam int unsigned RAMP_STEPS     = 256;
    localparam int unsigned TMR_W          = 32;

    // ----------------------------------------
    // Register map (command codes) and shadow EEPROM locations
    // ----------------------------------------
    localparam logic [7:0]  REG_MON4      = 8'h0F;
    localparam logic [7:0]  REG_SS_LOCK   = 8'h10;
    localparam logic [7:0]  REG_FAULT     = 8'h11;
    localparam logic [7:0]  REG_RESTART   = 8'h12;
    localparam logic [15:0] EE_BASE       = 16'h8100;
    localparam logic [7:0]  CFG_RESET_VAL = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

    // ----------------------------------------
    // Monitor-four modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        M4_DCOK_A = 3'h0,
        M4_DCOK_B = 3'h1,
        M4_POS_OV = 3'h2,
        M4_POS_UV = 3'h3,
        M4_NEG_OV = 3'h4,
        M4_NEG_UV = 3'h5,
        M4_FLAG   = 3'h6,
        M4_FLAG_N = 3'h7
    } psv_m4_mode_t;

    // ----------------------------------------
    // Field layouts
    // ----------------------------------------
    typedef struct packed {
        psv_m4_mode_t mode;
        logic [4:0]   spare;
    } psv_mon4_t;

    typedef struct packed {
        logic [3:0] spare;
        logic [1:0] rise;
        logic       addr_bit;
        logic       lock;
    } psv_ss_t;

    typedef struct packed {
        logic       oc_mask;
        logic       pen_pol;
        logic       fault_pol;
        logic [1:0] spare;
        logic       fast_rt;
        logic       gnd_dis;
        logic       latch;
    } psv_flt_t;

    typedef struct packed {
        logic       restart;
        logic       micro_ac_good_output;
        logic       micro_ac_sense;
        logic [1:0] rt_sel;
        logic       ac_mode;
        logic       micro_pson;
        logic       clamp88;
    } psv_rst_t;

    // Synchronised pin bundle
    typedef struct packed {
        logic overcurrent;
        logic ground_ok;
        logic ov_fault;
        logic uv_fault;
        logic on_request;
        logic mains_present;
        logic ac_sense_one;
        logic ac_sense_alt;
        logic m4_above_1v15;
        logic m4_above_1v25;
        logic m4_above_1v35;
    } psv_pins_t;

    localparam int unsigned PIN_W = $bits(psv_pins_t);

    // Power-up load sequencer
    typedef enum logic [2:0] {
        LD_MON4  = 3'h0,
        LD_SS    = 3'h1,
        LD_FAULT = 3'h3,
        LD_RST   = 3'h2,
        LD_RUN   = 3'h6
    } psv_ld_state_t;
endpackage : psv_pkg

// ### hw/psv_timer.sv
// Cycle timer: counts while enabled and pulses on each completed period
`timescale 1ns/10ps
module psv_timer
    import psv_pkg::*;
(
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    // Control
    input  wire logic             i_run,
    input  wire logic [TMR_W-1:0] i_period,
    // Status
    output logic                  o_hit
);
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] last;

    assign last  = (i_period == '0) ? '0 : i_period - TMR_W'(1);
    assign o_hit = i_run && (cnt_q >= last);

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else if (!i_run || o_hit) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + TMR_W'(1);
        end
    end
endmodule : psv_timer

// ### verif/psv_config_regs_properties.sv
// Checker: port timing of the configuration bank
`timescale 1ns/10ps
module psv_config_regs_properties
    import psv_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    // Register port
    input  wire logic        i_smb_wr,
    input  wire logic        i_smb_rd,
    input  wire logic        o_smb_ack,
    input  wire logic        o_smb_nack,
    // Load port
    input  wire logic        o_ee_rd_req,
    input  wire logic [15:0] o_ee_rd_addr,
    input  wire logic        i_ee_rd_valid,
    input  wire logic        o_cfg_loaded,
    // Function
    input  wire psv_pins_t   i_pins,
    input  wire logic        o_mon4_ov,
    input  wire logic        o_mon4_uv,
    input  wire logic        o_oc_status
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_req; i_smb_wr || i_smb_rd; endsequence
    sequence s_take; o_ee_rd_req && i_ee_rd_valid; endsequence
    property p_one_answer; s_req |=> o_smb_ack != o_smb_nack; endproperty
    property p_no_answer; !(i_smb_wr || i_smb_rd) |=> !o_smb_ack && !o_smb_nack; endproperty
    property p_early; s_req ##0 !o_cfg_loaded |=> o_smb_nack; endproperty
    property p_load_req; !o_cfg_loaded |-> o_ee_rd_req; endproperty
    property p_load_hold; o_ee_rd_req && !i_ee_rd_valid |=> $stable(o_ee_rd_addr); endproperty
    property p_load_step;
        s_take ##0 o_ee_rd_addr != 16'h8112 |=> o_ee_rd_addr == $past(o_ee_rd_addr) + 16'h0001;
    endproperty
    property p_load_done; s_take ##0 o_ee_rd_addr == 16'h8112 |=> o_cfg_loaded; endproperty
    property p_ind_excl; !(o_mon4_ov && o_mon4_uv); endproperty
    property p_oc_status;
        $rose(i_pins.overcurrent) ##1 i_pins.overcurrent [*2] |-> ##[0:1] o_oc_status;
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("no single answer");
    a_no_answer: assert property (p_no_answer)
        else $error("stray answer");
    a_early: assert property (p_early)
        else $error("early access taken");
    a_load_req: assert property (p_load_req)
        else $error("load idle");
    a_load_hold: assert property (p_load_hold)
        else $error("load addr moved");
    a_load_step: assert property (p_load_step)
        else $error("load addr no step");
    a_load_done: assert property (p_load_done)
        else $error("load unfinished");
    a_ind_excl: assert property (p_ind_excl)
        else $error("ov and uv together");
    a_oc_status: assert property (p_oc_status)
        else $error("oc status missing");
endmodule : psv_config_regs_properties

bind psv_config_regs psv_config_regs_properties psv_config_regs_properties_i (.i_sys_clk,
    .i_reset_n, .i_smb_wr, .i_smb_rd, .o_smb_ack, .o_smb_nack, .o_ee_rd_req, .o_ee_rd_addr,
    .i_ee_rd_valid, .o_cfg_loaded, .i_pins, .o_mon4_ov, .o_mon4_uv, .o_oc_status);

// ### verif/psv_ee_model.sv
// Shadow memory model: answers load reads after a delay
`timescale 1ns/10ps
module psv_ee_model (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    // Load port
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic [31:0] i_image,
    output logic             o_valid,
    output logic [7:0]       o_data
);
    logic [1:0] cnt_q;
    logic [1:0] idx;
    assign idx = i_addr[1:0] + 2'h1;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_q   <= 2'h0;
            o_valid <= 1'b0;
            o_data  <= 8'hA5;
        end else begin
            o_valid <= 1'b0;
            o_data  <= ~o_data;
            if (i_req && !o_valid) begin
                if (cnt_q == idx) begin
                    o_valid <= 1'b1;
                    o_data  <= i_image[8*idx +: 8];
                    cnt_q   <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule : psv_ee_model

// ### verif/tb_psv_config_regs.sv
// Testbench for the supervisor configuration bank
`timescale 1ns/10ps
module tb_psv_config_regs import psv_pkg::*; ;
    localparam logic [31:0] IMG     = 32'h0020_0040;
    localparam logic [5:0]  M4X [8] = '{6'h00, 6'h00, 6'h06, 6'h0C, 6'h14, 6'h05, 6'h04, 6'h00};
    logic       i_sys_clk, i_reset_n, i_smb_wr, i_smb_rd, i_test_download, i_ee_rd_valid;
    logic       o_smb_ack, o_smb_nack, o_ee_rd_req, o_cfg_loaded, o_mon4_pin_o, o_mon4_pin_oe;
    logic       o_mon4_flag, o_mon4_ov, o_mon4_uv, o_fault_indicator_output, o_oc_status;
    logic       i_dc_good_internal, i_host_mains_gate, i_host_ac_sense, i_host_on_request;
    logic [7:0] i_smb_cmd, i_smb_wdata, i_ee_rd_data, o_smb_rdata;
    logic [15:0] o_ee_rd_addr;
    psv_pins_t  i_pins;
    int         miscompares, total_checks;

    psv_config_regs #(.SS_T1_CYC(2560), .SS_T2_CYC(2560), .SS_T3_CYC(2560), .RT_SLOW_CYC(100))
        psv_config_regs_i (.i_sys_clk, .i_reset_n, .i_smb_wr, .i_smb_rd, .i_smb_cmd,
        .i_smb_wdata, .o_smb_rdata, .o_smb_ack, .o_smb_nack, .i_test_download, .o_ee_rd_req,
        .o_ee_rd_addr, .i_ee_rd_valid, .i_ee_rd_data, .o_cfg_loaded, .i_pins,
        .i_dc_good_internal, .i_host_mains_gate, .i_host_ac_sense,
        .i_host_on_request, .o_mon4_pin_o, .o_mon4_pin_oe, .o_mon4_flag, .o_mon4_ov,
        .o_mon4_uv, .o_power_enable_output(), .o_fault_indicator_output, .o_oc_status,
        .o_mains_status_output(), .o_ac_good_output(), .o_share_clamp_88(), .o_ref_level(),
        .o_softstart_done());
    psv_ee_model psv_ee_model_i (.i_sys_clk, .i_reset_n, .i_req(o_ee_rd_req),
        .i_addr(o_ee_rd_addr), .i_image(IMG), .o_valid(i_ee_rd_valid), .o_data(i_ee_rd_data));

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string n, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc
    task setp(input int b, input logic v);
        @(posedge i_sys_clk);
        i_pins[b] <= v;
        cyc(4);
    endtask : setp
    task xfer(input logic w, input logic [7:0] c, d, output logic [9:0] r);
        @(posedge i_sys_clk);
        i_smb_wr    <= w;
        i_smb_rd    <= !w;
        i_smb_cmd   <= c;
        i_smb_wdata <= d;
        @(posedge i_sys_clk);
        i_smb_wr <= 1'b0;
        i_smb_rd <= 1'b0;
        #1;
        r = {o_smb_ack, o_smb_nack, o_smb_rdata};
    endtask : xfer
    task wait_loaded;
        for (int k = 0; k < 60 && o_cfg_loaded !== 1'b1; k++) cyc(1);
        chk("loaded", o_cfg_loaded, 1'b1);
        if (o_cfg_loaded !== 1'b1) report_and_stop();
    endtask : wait_loaded
    task t_load;
        logic [9:0] r;
        xfer(1'b0, REG_MON4, 8'h00, r);
        chk("early", r[9:8], 2'b01);
        wait_loaded();
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, REG_MON4 + 8'(i), 8'h00, r);
            chk("image", r, {2'b10, IMG[8*i +: 8]});
        end
    endtask : t_load
    task t_mon4;
        logic [9:0] r;
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, REG_MON4, {3'(m), 5'h00}, r);
            for (int h = 0; h < 2; h++) begin
                @(posedge i_sys_clk);
                {i_dc_good_internal, i_pins[2:0]} <= {4{h[0]}};
                cyc(4);
                chk("oe", o_mon4_pin_oe, m < 2);
                if (m < 2) chk("dc", o_mon4_pin_o, h[0]);
                else chk("mon4", {o_mon4_flag, o_mon4_ov, o_mon4_uv}, M4X[m][3*(1-h) +: 3]);
            end
        end
    endtask : t_mon4
    task t_fault;
        logic [9:0] r;
        setp(8, 1'b1);
        chk("flt_on", o_fault_indicator_output, 1'b1);
        setp(8, 1'b0);
        chk("flt_off", o_fault_indicator_output, 1'b0);
        xfer(1'b1, REG_FAULT, 8'h01, r);
        setp(8, 1'b1);
        chk("flt_low", o_fault_indicator_output, 1'b0);
        setp(8, 1'b0);
        chk("flt_held", o_fault_indicator_output, 1'b0);
        setp(6, 1'b1);
        setp(6, 1'b0);
        chk("flt_clr", o_fault_indicator_output, 1'b1);
    endtask : t_fault
    task ride(input logic [7:0] f, t, input int lo, hi);
        logic [9:0] r;
        xfer(1'b1, REG_FAULT, f, r);
        xfer(1'b1, REG_RESTART, t, r);
        @(posedge i_sys_clk);
        i_pins.overcurrent <= 1'b1;
        cyc(lo);
        chk("ride_wait", o_fault_indicator_output, 1'b0);
        cyc(hi - lo);
        chk("ride_trip", o_fault_indicator_output, hi > 0);
        setp(10, 1'b0);
    endtask : ride
    task t_ride;
        ride(8'h24, 8'h00, 1250, 1310);
        ride(8'h24, 8'h18, 5090, 5150);
        ride(8'h20, 8'h18, 390, 420);
        ride(8'hA4, 8'h00, 1400, 0);
        setp(10, 1'b1);
        chk("oc_stat", o_oc_status, 1'b1);
        setp(10, 1'b0);
    endtask : t_ride
    task t_lock;
        logic [9:0] r;
        xfer(1'b1, REG_SS_LOCK, 8'h01, r);
        chk("lock", r[9:8], 2'b10);
        xfer(1'b1, REG_FAULT, 8'h55, r);
        chk("wr_lock", r[9:8], 2'b01);
        xfer(1'b1, REG_SS_LOCK, 8'h00, r);
        chk("self_lock", r[9:8], 2'b01);
        xfer(1'b0, REG_SS_LOCK, 8'h00, r);
        chk("lock_rd", r, {2'b10, 8'h01});
        xfer(1'b0, 8'h20, 8'h00, r);
        chk("unmapped", r[9:8], 2'b01);
        @(posedge i_sys_clk);
        i_test_download <= 1'b1;
        @(posedge i_sys_clk);
        i_test_download <= 1'b0;
        cyc(1);
        wait_loaded();
        xfer(1'b1, REG_FAULT, 8'h55, r);
        chk("reopen", r[9:8], 2'b10);
    endtask : t_lock

    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        {i_reset_n, i_smb_wr, i_smb_rd, i_test_download, i_dc_good_internal, i_smb_cmd,
         i_smb_wdata, i_host_mains_gate, i_host_ac_sense, i_host_on_request} = '0;
        i_pins = '0;
        i_pins.ground_ok = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        t_load();
        t_mon4();
        t_fault();
        t_ride();
        t_lock();
        report_and_stop();
    end
endmodule : tb_psv_config_regs
